// *** tb/iaos_host_model.sv ***
// Host model that reads status and data registers and issues the software reset
`default_nettype none
module iaos_host_model (
    input wire logic clk_i,
    input wire logic rd_valid_i,
    input wire logic [15:0] rd_data_i,
    output logic rd_req_o,
    output logic [6:0] rd_addr_o,
    output logic sw_reset_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rd_req_o = 1'b0;
        rd_addr_o = 7'h00;
        sw_reset_o = 1'b0;
    end
    // One-cycle request; data and valid are taken half a cycle after the answering edge
    task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic v);
        @(negedge clk_i);
        rd_req_o = 1'b1;
        rd_addr_o = a;
        @(negedge clk_i);
        rd_req_o = 1'b0;
        rd_addr_o = ~a;
        v = rd_valid_i;
        d = rd_data_i;
    endtask
    // Software reset command, the only way out of an overrun
    task automatic sw_reset();
        @(negedge clk_i);
        sw_reset_o = 1'b1;
        @(negedge clk_i);
        sw_reset_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** tb/iaos_regs_tb_top.sv ***
// Self-checking testbench of the status and output register bank
`default_nettype none
module iaos_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic rd_req, rd_valid, sw_reset, v;
    logic st_done = 1'b0;
    logic su_done = 1'b0;
    logic [6:0] rd_addr;
    logic [15:0] rd_data, sys_err, diag, alm, d, e;
    logic [15:0] temp = 16'h0000;
    logic [15:0] fail = 16'h0000;
    logic [15:0] alarm = 16'h0000;
    iaos_pkg::iaos_field_t field = '0;
    iaos_pkg::iaos_press_t press = '0;
    iaos_pkg::iaos_err_t err = '0;
    logic [31:0] seed = 32'hcc155552;
    int num_errors = 0;
    int comparisons = 0;
    always #4 sys_clk_i = ~sys_clk_i;
    iaos_regs #(.FIELD_PERIOD(20), .PRESS_PERIOD(40)) uut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .rd_req_i(rd_req), .rd_addr_i(rd_addr), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .field_i(field),
        .press_i(press), .temp_i(temp), .err_i(err), .sw_reset_i(sw_reset), .self_test_fail_i(fail),
        .self_test_done_i(st_done), .startup_test_done_i(su_done), .alarm_i(alarm), .sys_err_o(sys_err),
        .diag_o(diag), .alarm_o(alm));
    iaos_host_model host (.clk_i(sys_clk_i), .rd_valid_i(rd_valid), .rd_data_i(rd_data), .rd_req_o(rd_req),
        .rd_addr_o(rd_addr), .sw_reset_o(sw_reset));
    // ==========================================
    // Expectation helpers and reporting
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] diag_exp(input logic [15:0] f, input logic cmd);
        return f & 16'h0f3f & (cmd ? 16'hf7ff : 16'hffff);
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [6:0] a, input logic [15:0] m, input logic [15:0] exp);
        host.rd(a, d, v);
        check({15'h0000, v}, 16'h0001);
        check(d & m, exp & m);
    endtask
    task automatic wait_bit(input int b);
        int n;
        n = 0;
        while (sys_err[b] !== 1'b1 && n < 100) begin
            @(negedge sys_clk_i);
            n++;
        end
        if (n == 100) check(16'h0000, 16'h0001);
    endtask
    task automatic summarize();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        num_errors++;
        summarize();
    end
    // ==========================================
    // Main sequence
    initial begin
        repeat (5) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        for (int i = 0; i < 4; i++) rdc(7'h08 + 7'(2 * i), 16'hffff, 16'h0000);
        rdc(7'h10, 16'hffff, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            field.x = seed[15:0];
            field.y = seed[31:16];
            seed = lfsr(seed);
            field.z = seed[15:0];
            temp = seed[31:16];
            seed = lfsr(seed);
            press = seed;
            if (k == 0) begin
                field = {16'h7fff, 16'h8000, 16'hffff};
                press = 32'h8000_0001;
            end
            repeat (80) @(negedge sys_clk_i);
            wait_bit(9);
            rdc(7'h30, 16'hffff, press.hi);
            rdc(7'h2e, 16'hffff, press.lo);
            rdc(7'h08, 16'h0200, 16'h0000);
            wait_bit(8);
            rdc(7'h2a, 16'hffff, field.y);
            rdc(7'h08, 16'h0100, 16'h0000);
            rdc(7'h28, 16'hffff, field.x);
            rdc(7'h2c, 16'hffff, field.z);
            rdc(7'h0e, 16'hffff, temp);
        end
        err = 5'b10111;
        @(negedge sys_clk_i);
        rdc(7'h08, 16'hfcff, 16'h8058);
        rdc(7'h08, 16'hfcff, 16'h8058);
        err = '0;
        rdc(7'h08, 16'hfcff, 16'h8058);
        rdc(7'h08, 16'hfcff, 16'h0000);
        err = 5'b01000;
        @(negedge sys_clk_i);
        err = '0;
        rdc(7'h08, 16'hfcff, 16'h0080);
        rdc(7'h08, 16'hfcff, 16'h0080);
        check(sys_err & 16'hfcff, 16'h0080);
        host.sw_reset();
        rdc(7'h08, 16'hfcff, 16'h0000);
        for (int j = 0; j < 3; j++) begin
            seed = lfsr(seed);
            fail = (j > 0) ? 16'hffff : (seed[15:0] | 16'h0001);
            st_done = (j == 1);
            su_done = (j != 1);
            @(negedge sys_clk_i);
            st_done = 1'b0;
            su_done = 1'b0;
            rdc(7'h08, 16'h0020, 16'h0020);
            rdc(7'h0a, 16'hffff, diag_exp(fail, j == 1));
            rdc(7'h0a, 16'hffff, 16'h0000);
        end
        seed = lfsr(seed);
        e = seed[15:0] | 16'h0800;
        alarm = e;
        @(negedge sys_clk_i);
        alarm = 16'h0000;
        rdc(7'h08, 16'h0001, 16'h0001);
        rdc(7'h0c, 16'hffff, e & 16'h0f3f);
        rdc(7'h0c, 16'hffff, 16'h0000);
        check(alm, 16'h0000);
        check(diag, 16'h0000);
        summarize();
    end
endmodule
`default_nettype wire

// *** verilog/iaos_pkg.sv ***
// Package for the auxiliary output and status register bank
`default_nettype none
package iaos_pkg;
    // Page 0 byte offsets of the register bank
    localparam logic [6:0] ADDR_SYS_ERR = 7'h08;
    localparam logic [6:0] ADDR_DIAG = 7'h0a;
    localparam logic [6:0] ADDR_ALARM = 7'h0c;
    localparam logic [6:0] ADDR_TEMP = 7'h0e;
    localparam logic [6:0] ADDR_FIELD_X = 7'h28;
    localparam logic [6:0] ADDR_FIELD_Y = 7'h2a;
    localparam logic [6:0] ADDR_FIELD_Z = 7'h2c;
    localparam logic [6:0] ADDR_PRESS_LO = 7'h2e;
    localparam logic [6:0] ADDR_PRESS_HI = 7'h30;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    // System error flag bit positions
    localparam int BIT_WDOG = 15;
    localparam int BIT_NEW_PRESS = 9;
    localparam int BIT_NEW_FIELD = 8;
    localparam int BIT_OVERRUN = 7;
    localparam int BIT_FLASH_FAIL = 6;
    localparam int BIT_SELF_TEST = 5;
    localparam int BIT_OVERRANGE = 4;
    localparam int BIT_SERIAL_ERR = 3;
    localparam int BIT_ALARM = 0;
    // Implemented bits of each status register
    localparam logic [15:0] SYS_ERR_MASK = 16'h83f9;
    localparam logic [15:0] SENSOR_MASK = 16'h0f3f;
    localparam logic [15:0] PRESS_BIT_MASK = 16'h0800;
    // Sample periods: 125 MHz / 102.5 SPS and 125 MHz / 51.25 SPS
    localparam int CLK_HZ = 125000000;
    localparam int FIELD_RATE_MSPS = 102500;
    localparam int PRESS_RATE_MSPS = 51250;
    localparam int FIELD_PERIOD_CYC = int'((64'(CLK_HZ) * 1000) / FIELD_RATE_MSPS);
    localparam int PRESS_PERIOD_CYC = int'((64'(CLK_HZ) * 1000) / PRESS_RATE_MSPS);
    localparam int SERIAL_WORD_BITS = 16;

    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
    } iaos_field_t;

    typedef struct packed {
        logic [15:0] hi;
        logic [15:0] lo;
    } iaos_press_t;

    // Error condition inputs from the internal processor
    typedef struct packed {
        logic wdog;
        logic overrun;
        logic flash_fail;
        logic overrange;
        logic serial_err;
    } iaos_err_t;

    typedef struct packed {
        logic [15:0] sys_err;
        logic [15:0] diag;
        logic [15:0] alarm;
        logic [15:0] temp;
        iaos_field_t field;
        iaos_press_t press;
        logic [31:0] field_cnt;
        logic [31:0] press_cnt;
        logic [15:0] rd_data;
        logic rd_valid;
    } iaos_state_t;
endpackage
`default_nettype wire

// *** verilog/iaos_regs.sv ***
// Read-only output and clear-on-read status register bank
`default_nettype none
// Function
// - Field words are signed, tenth milligauss counts
// - Pressure high and low form 32 bits
// - Pressure high word signed, 40 microbar counts
// - Pressure low word MSB weighs 20 microbar
// - Temperature signed, zero means 25 C
// - Error register read clears all but overrun
// - Overrun holds until software reset command
// - Persisting error conditions set again after read
// - Bit 15 flags watchdog timeout
// - Bit 9 new pressure, cleared by high read
// - Bit 8 new field, cleared by axis read
// - Bit 7 flags processing overrun
// - Bit 6 flags failed flash update
// - Bit 5 set while diagnostics nonzero
// - Bit 4 flags sensor overrange
// - Bit 3 flags transfer not multiple of 16
// - Bit 0 set while alarms nonzero
// - Diagnostics hold per-sensor self-test failure bits
// - Pressure failure bit only from start-up reset
// - Diagnostics and alarm read clears them
// - Alarm bits per sensor, bit 11 pressure
// - Field and pressure words update at fixed rates
module iaos_regs #(
    parameter int FIELD_PERIOD = iaos_pkg::FIELD_PERIOD_CYC,
    parameter int PRESS_PERIOD = iaos_pkg::PRESS_PERIOD_CYC
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Register read port from the serial front end
    input wire logic rd_req_i,
    input wire logic [6:0] rd_addr_i,
    output logic [15:0] rd_data_o,
    output logic rd_valid_o,
    // Sensor data from the processing core
    input wire iaos_pkg::iaos_field_t field_i,
    input wire iaos_pkg::iaos_press_t press_i,
    input wire logic [15:0] temp_i,
    input wire iaos_pkg::iaos_err_t err_i,
    input wire logic sw_reset_i,
    input wire logic [15:0] self_test_fail_i,
    input wire logic self_test_done_i,
    input wire logic startup_test_done_i,
    input wire logic [15:0] alarm_i,
    // Status snapshot for the processor
    output logic [15:0] sys_err_o,
    output logic [15:0] diag_o,
    output logic [15:0] alarm_o
);
    // ==========================================================
    // State
    // ==========================================================
    iaos_pkg::iaos_state_t st;
    iaos_pkg::iaos_state_t next_st;

    logic rd_sys;
    logic rd_diag;
    logic rd_alarm;
    logic rd_field;
    logic rd_press_hi;
    logic field_tick;
    logic press_tick;
    logic [15:0] err_set;
    logic [15:0] kept;
    logic [15:0] next_diag;
    logic [15:0] next_alarm;

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        next_st = st;
        rd_sys = rd_req_i && rd_addr_i == iaos_pkg::ADDR_SYS_ERR;
        rd_diag = rd_req_i && rd_addr_i == iaos_pkg::ADDR_DIAG;
        rd_alarm = rd_req_i && rd_addr_i == iaos_pkg::ADDR_ALARM;
        rd_field = rd_req_i && (rd_addr_i == iaos_pkg::ADDR_FIELD_X || rd_addr_i == iaos_pkg::ADDR_FIELD_Y
                   || rd_addr_i == iaos_pkg::ADDR_FIELD_Z);
        rd_press_hi = rd_req_i && rd_addr_i == iaos_pkg::ADDR_PRESS_HI;
        field_tick = st.field_cnt >= 32'(FIELD_PERIOD - 1);
        press_tick = st.press_cnt >= 32'(PRESS_PERIOD - 1);

        // Fixed-rate sampling of field and pressure words
        next_st.field_cnt = field_tick ? '0 : st.field_cnt + 32'h1;
        next_st.press_cnt = press_tick ? '0 : st.press_cnt + 32'h1;
        if (field_tick) begin
            next_st.field = field_i;
        end
        if (press_tick) begin
            next_st.press = press_i;
        end
        next_st.temp = temp_i;

        // Diagnostics: commanded test never touches the pressure bit
        next_diag = rd_diag ? iaos_pkg::RESET_WORD : st.diag;
        if (self_test_done_i) begin
            next_diag = next_diag | (self_test_fail_i & iaos_pkg::SENSOR_MASK & ~iaos_pkg::PRESS_BIT_MASK);
        end
        if (startup_test_done_i) begin
            next_diag = next_diag | (self_test_fail_i & iaos_pkg::SENSOR_MASK);
        end
        next_st.diag = next_diag & iaos_pkg::SENSOR_MASK;

        // Alarms: set wins over read clear
        next_alarm = (rd_alarm ? iaos_pkg::RESET_WORD : st.alarm) | alarm_i;
        next_st.alarm = next_alarm & iaos_pkg::SENSOR_MASK;

        // Error flags: live conditions re-set after a clearing read
        err_set = '0;
        err_set[iaos_pkg::BIT_WDOG] = err_i.wdog;
        err_set[iaos_pkg::BIT_NEW_PRESS] = press_tick;
        err_set[iaos_pkg::BIT_NEW_FIELD] = field_tick;
        err_set[iaos_pkg::BIT_OVERRUN] = err_i.overrun;
        err_set[iaos_pkg::BIT_FLASH_FAIL] = err_i.flash_fail;
        err_set[iaos_pkg::BIT_SELF_TEST] = |next_st.diag;
        err_set[iaos_pkg::BIT_OVERRANGE] = err_i.overrange;
        err_set[iaos_pkg::BIT_SERIAL_ERR] = err_i.serial_err;
        err_set[iaos_pkg::BIT_ALARM] = |next_st.alarm;
        kept = st.sys_err;
        if (rd_sys) begin
            kept = st.sys_err & (16'h1 << iaos_pkg::BIT_OVERRUN);
        end
        if (rd_press_hi) begin
            kept[iaos_pkg::BIT_NEW_PRESS] = 1'b0;
        end
        if (rd_field) begin
            kept[iaos_pkg::BIT_NEW_FIELD] = 1'b0;
        end
        if (sw_reset_i) begin
            kept[iaos_pkg::BIT_OVERRUN] = 1'b0;
        end
        // Flash flag holds after the condition drops, until a status read clears it
        kept[iaos_pkg::BIT_FLASH_FAIL] = 1'b0;
        kept[iaos_pkg::BIT_SELF_TEST] = rd_sys ? 1'b0 : st.sys_err[iaos_pkg::BIT_SELF_TEST];
        next_st.sys_err = (kept | err_set) & iaos_pkg::SYS_ERR_MASK;
        if (!rd_sys && st.sys_err[iaos_pkg::BIT_FLASH_FAIL] && !err_i.flash_fail) begin
            next_st.sys_err[iaos_pkg::BIT_FLASH_FAIL] = 1'b1;
        end

        // Read mux, answer one cycle after request
        next_st.rd_valid = rd_req_i;
        unique case (rd_addr_i)
            iaos_pkg::ADDR_SYS_ERR: next_st.rd_data = st.sys_err;
            iaos_pkg::ADDR_DIAG: next_st.rd_data = st.diag;
            iaos_pkg::ADDR_ALARM: next_st.rd_data = st.alarm;
            iaos_pkg::ADDR_TEMP: next_st.rd_data = st.temp;
            iaos_pkg::ADDR_FIELD_X: next_st.rd_data = st.field.x;
            iaos_pkg::ADDR_FIELD_Y: next_st.rd_data = st.field.y;
            iaos_pkg::ADDR_FIELD_Z: next_st.rd_data = st.field.z;
            iaos_pkg::ADDR_PRESS_LO: next_st.rd_data = st.press.lo;
            iaos_pkg::ADDR_PRESS_HI: next_st.rd_data = st.press.hi;
            default: next_st.rd_data = iaos_pkg::RESET_WORD;
        endcase
        if (!rd_req_i) begin
            next_st.rd_data = st.rd_data;
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rd_data_o = st.rd_data;
    assign rd_valid_o = st.rd_valid;
    assign sys_err_o = st.sys_err;
    assign diag_o = st.diag;
    assign alarm_o = st.alarm;

    // ==========================================================
    // Assertions
    // ==========================================================
    AST_READ_CLEAR_KEEPS_OVERRUN: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        rd_sys && !err_i.overrun && !sw_reset_i && st.sys_err[iaos_pkg::BIT_OVERRUN]
        |=> st.sys_err[iaos_pkg::BIT_OVERRUN])
        else $error("Overrun flag lost on status read");
    AST_OVERRUN_STICKY: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        st.sys_err[iaos_pkg::BIT_OVERRUN] && !sw_reset_i |=> st.sys_err[iaos_pkg::BIT_OVERRUN])
        else $error("Overrun flag dropped without software reset");
    AST_WDOG_RESET: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        err_i.wdog |=> st.sys_err[iaos_pkg::BIT_WDOG])
        else $error("Watchdog flag not set");
    AST_PRESS_NEW_CLEAR: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        rd_press_hi && !press_tick |=> !st.sys_err[iaos_pkg::BIT_NEW_PRESS])
        else $error("New pressure flag not cleared by read");
    AST_FIELD_NEW_CLEAR: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        rd_field && !field_tick |=> !st.sys_err[iaos_pkg::BIT_NEW_FIELD])
        else $error("New field flag not cleared by read");
    AST_DIAG_SUMMARY: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        st.sys_err[iaos_pkg::BIT_SELF_TEST] || st.diag == 16'h0000)
        else $error("Self-test summary missing");
    AST_ALARM_SUMMARY: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        st.sys_err[iaos_pkg::BIT_ALARM] || st.alarm == 16'h0000)
        else $error("Alarm summary missing");
    AST_DIAG_READ_CLEAR: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        rd_diag && !self_test_done_i && !startup_test_done_i |=> st.diag == 16'h0000)
        else $error("Diagnostics not cleared by read");
    AST_PRESS_BIT_ONLY_STARTUP: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (st.diag & iaos_pkg::PRESS_BIT_MASK) == 16'h0000 && !startup_test_done_i
        |=> (st.diag & iaos_pkg::PRESS_BIT_MASK) == 16'h0000)
        else $error("Pressure self-test bit set by commanded test");
    AST_UNUSED_ZERO: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (st.sys_err & ~iaos_pkg::SYS_ERR_MASK) == 16'h0000 && (st.alarm & ~iaos_pkg::SENSOR_MASK) == 16'h0000)
        else $error("Unused status bit set");
    AST_READ_LATENCY: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        rd_req_i && rd_addr_i == iaos_pkg::ADDR_PRESS_HI |=> rd_valid_o && rd_data_o == $past(st.press.hi))
        else $error("Pressure high read data wrong");
    COV_FIELD_NEW: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) field_tick ##[1:20] rd_field);
    COV_PRESS_NEW: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) press_tick ##[1:20] rd_press_hi);
    COV_OVERRUN_RESET: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        st.sys_err[iaos_pkg::BIT_OVERRUN] ##1 sw_reset_i);
    COV_ALARM_READ: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) st.alarm != 16'h0000 && rd_alarm);
endmodule
`default_nettype wire
